// ===== hdl/coproc_pkg.sv
// constants and types shared by the coprocessor core and its alu
package coproc_pkg;
    localparam int PC_W = 11;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;
    localparam int NUM_GPR = 4;
    // opcode sits in [31:28], subfield in [27:25]
    localparam logic [3:0] ALU_OPCODE = 4'h7;
    localparam logic [3:0] STORE_WORD_OP = 4'h6;
    localparam logic [3:0] LOAD_WORD_OP = 4'hD;
    localparam logic [3:0] JUMP_OPCODE = 4'h8;
    localparam logic [2:0] ALU_REG_FORM = 3'h0;
    localparam logic [2:0] ALU_IMM_FORM = 3'h1;
    localparam logic [2:0] ALU_CNT_FORM = 3'h2;
    localparam logic [2:0] STORE_SUBFIELD = 3'h4;
    localparam logic [2:0] JUMP_ABS_FORM = 3'h0;
    localparam logic [2:0] JUMP_REG_ZERO_FORM = 3'h1;
    localparam logic [2:0] JUMP_CNT_FORM = 3'h2;
    // alu_op_select codes
    localparam logic [3:0] ADD_OP = 4'h0;
    localparam logic [3:0] SUB_OP = 4'h1;
    localparam logic [3:0] AND_OP = 4'h2;
    localparam logic [3:0] OR_OP = 4'h3;
    localparam logic [3:0] MOVE_OP = 4'h4;
    localparam logic [3:0] SHIFT_LEFT_OP = 4'h5;
    localparam logic [3:0] SHIFT_RIGHT_OP = 4'h6;
    localparam logic [3:0] CNT_INC_OP = 4'h0;
    localparam logic [3:0] COUNTER_DECREMENT_OP = 4'h1;
    localparam logic [3:0] CNT_CLEAR_OP = 4'h2;
    // absolute jump types
    localparam logic [2:0] JT_ALWAYS = 3'h0;
    localparam logic [2:0] JT_ZERO = 3'h1;
    localparam logic [2:0] JT_OVF = 3'h2;
    localparam logic [4:0] STORE_PAD = 5'h00;
    // byte address of coprocessor word 0 as the main processor sees it
    localparam logic [31:0] SHARED_MEM_CPU_BASE = 32'h5000_0000;
    // register map, byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PC_INIT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] GPR_OFS = 8'h10;
    localparam int CTRL_START_BIT = 0;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_FETCH = 4'b0010,
        S_EXEC = 4'b0100,
        S_MEM = 4'b1000
    } state_type;
endpackage

// ===== hdl/alu_if.sv
// operand and result bundle between the core and its alu
`timescale 1ns/10ps
interface alu_if;
    import coproc_pkg::*;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [3:0] sel;
    logic [DATA_W-1:0] result;
    logic carry;
    logic zero;
    modport core_side(output a, output b, output sel, input result, input carry, input zero);
    modport alu_side(input a, input b, input sel, output result, output carry, output zero);
endinterface

// ===== hdl/coproc_alu.sv
// sixteen-bit alu of the coprocessor
`timescale 1ns/10ps
module coproc_alu
    import coproc_pkg::*;
(
    // clock and reset, used by the checks only
    input wire logic clk,
    input wire logic rst_n,
    // operands and result
    alu_if.alu_side bus
);
    wire [DATA_W:0] sum = {1'b0, bus.a} + {1'b0, bus.b};
    wire [DATA_W:0] diff = {1'b0, bus.a} - {1'b0, bus.b};
    wire [DATA_W-1:0] shl = bus.a << bus.b;
    wire [DATA_W-1:0] shr = bus.a >> bus.b;

    // carry of an add, borrow of a subtract
    assign bus.carry = (bus.sel == SUB_OP) ? diff[DATA_W] : sum[DATA_W];
    assign bus.result =
        (bus.sel == ADD_OP) ? sum[DATA_W-1:0] :
        (bus.sel == SUB_OP) ? diff[DATA_W-1:0] :
        (bus.sel == AND_OP) ? (bus.a & bus.b) :
        (bus.sel == OR_OP) ? (bus.a | bus.b) :
        (bus.sel == SHIFT_LEFT_OP) ? shl :
        (bus.sel == SHIFT_RIGHT_OP) ? shr :
        bus.a;
    assign bus.zero = (bus.result == 16'h0000);

    property p_sub_borrow;
        @(posedge clk) disable iff (!rst_n)
        (bus.sel == SUB_OP) |-> (bus.carry == (bus.a < bus.b));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow wrong");

    property p_shift_right;
        @(posedge clk) disable iff (!rst_n)
        (bus.sel == SHIFT_RIGHT_OP && bus.b >= 16'h0010) |-> (bus.result == 16'h0000);
    endproperty
    a_shift_right: assert property (p_shift_right) else $error("long shift wrong");
endmodule // coproc_alu

// ===== hdl/coproc_core.sv
// coprocessor core: fetch, alu, load/store and jump execution
// Operation
// - sub-field zero: alu works on general registers, two sources, one destination
// - select codes: add, subtract, and, or, copy, shift left, shift right
// - add and subtract set or clear the overflow flag
// - every alu operation sets zero flag from its result
// - sub-field one: second operand is signed 16-bit immediate from bits 19:4
// - immediate form uses same codes; copy writes the immediate itself
// - sub-field two: alu works on 8-bit stage counter with 8-bit immediate
// - counter codes: 0 add, 1 subtract, 2 clear
// - store writes program counter and five zero bits into upper half
// - store puts source value in low half at base plus offset
// - offsets are signed 10-bit; addresses count 32-bit words
// - only whole words; word 0 is processor byte address 0x50000000
// - load copies low half of word into destination register
// - absolute jump target from 11-bit immediate in bits 12:2 or from a register
// - jump type: always, on zero flag, on overflow flag
// - relative step is sign-magnitude: bit 7 picks add or subtract
// - register-zero branch: below threshold or at-or-above, per condition bit
// - counter branch: 1x equal, 00 less, 01 greater
// - four 16-bit general registers
// - every instruction is one 32-bit word, opcode on top
`timescale 1ns/10ps
module coproc_core
    import coproc_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // ahb-lite register slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // shared slow memory, word addressed
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [PC_W-1:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA,
    input wire logic MEM_ACK
);
    state_type state;
    logic [31:0] instr;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pc_init;
    logic [DATA_W-1:0] gpr [NUM_GPR];
    logic [CNT_W-1:0] stage_cnt;
    logic zero_flag;
    logic ovf_flag;
    logic halted;
    logic wr_pending;
    logic [7:0] wr_addr;
    logic start_req;

    alu_if alu_bus();

    coproc_alu u_alu (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .bus(alu_bus.alu_side)
    );

    // instruction fields, one 32-bit word each
    wire [3:0] opcode = instr[31:28];
    wire [2:0] sub = instr[27:25];
    wire [3:0] alu_op_select = instr[24:21];
    wire [1:0] dest_index = instr[1:0];
    wire [1:0] first_source_index = instr[3:2];
    wire [1:0] second_source_index = instr[5:4];
    wire [DATA_W-1:0] imm16 = instr[19:4];
    wire [CNT_W-1:0] imm8 = instr[11:4];
    wire [DATA_W-1:0] mem_offset = 16'($signed(instr[19:10]));
    wire [7:0] step = instr[24:17];
    wire [2:0] jump_type = instr[24:22];

    wire exec = (state == S_EXEC);
    wire is_alu = (opcode == ALU_OPCODE);
    wire alu_reg = is_alu && (sub == ALU_REG_FORM);
    wire alu_imm = is_alu && (sub == ALU_IMM_FORM);
    wire alu_cnt = is_alu && (sub == ALU_CNT_FORM);
    wire is_store = (opcode == STORE_WORD_OP) && (sub == STORE_SUBFIELD);
    wire is_load = (opcode == LOAD_WORD_OP);
    wire is_jump = (opcode == JUMP_OPCODE);
    wire jump_abs = is_jump && (sub == JUMP_ABS_FORM);
    wire jump_reg_zero = is_jump && (sub == JUMP_REG_ZERO_FORM);
    wire jump_cnt = is_jump && (sub == JUMP_CNT_FORM);
    wire known = alu_reg | alu_imm | alu_cnt | is_store | is_load |
                 jump_abs | jump_reg_zero | jump_cnt;
    wire arith = (alu_op_select == ADD_OP) || (alu_op_select == SUB_OP);

    // operand routing; immediate copy goes through the alu as its first operand
    assign alu_bus.sel = alu_op_select;
    assign alu_bus.a = (alu_imm && alu_op_select == MOVE_OP) ? imm16 :
                       gpr[first_source_index];
    assign alu_bus.b = alu_imm ? imm16 : gpr[second_source_index];

    // stage counter arithmetic wraps modulo 256
    wire [CNT_W-1:0] next_cnt =
        (alu_op_select == CNT_INC_OP) ? stage_cnt + imm8 :
        (alu_op_select == COUNTER_DECREMENT_OP) ? stage_cnt - imm8 :
        (alu_op_select == CNT_CLEAR_OP) ? 8'h00 :
        stage_cnt;

    // load and store share base in [3:2] and data register in [1:0]
    wire [DATA_W-1:0] ls_addr = gpr[first_source_index] + mem_offset;
    wire [PC_W-1:0] ls_word = ls_addr[PC_W-1:0];
    wire [DATA_W-1:0] store_data = gpr[dest_index];
    wire [DATA_W-1:0] mem_low = MEM_RDATA[DATA_W-1:0];

    // jump targets and conditions
    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                   input logic [7:0] delta);
        rel_target = delta[7] ? base - PC_W'(delta[6:0]) : base + PC_W'(delta[6:0]);
    endfunction

    wire abs_take = (jump_type == JT_ALWAYS) ||
                    (jump_type == JT_ZERO && zero_flag) ||
                    (jump_type == JT_OVF && ovf_flag);
    wire [PC_W-1:0] abs_target = instr[21] ? gpr[dest_index][PC_W-1:0] :
                                 instr[2 +: PC_W];
    wire reg_zero_take = instr[16] ? (gpr[0] >= instr[15:0]) :
                         (gpr[0] < instr[15:0]);
    wire cnt_take = instr[16] ? (stage_cnt == instr[7:0]) :
                    instr[15] ? (stage_cnt > instr[7:0]) :
                    (stage_cnt < instr[7:0]);
    wire [PC_W-1:0] pc_step = rel_target(pc, step);
    wire [PC_W-1:0] pc_inc = pc + 11'h001;
    wire rel_take = (jump_reg_zero && reg_zero_take) || (jump_cnt && cnt_take);
    wire [PC_W-1:0] next_pc = (jump_abs && abs_take) ? abs_target :
                              rel_take ? pc_step :
                              pc_inc;

    // sequencer and memory port
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            state <= S_IDLE;
            instr <= 32'h0000_0000;
            pc <= 11'h000;
            halted <= 1'b0;
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_ADDR <= 11'h000;
            MEM_WDATA <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (start_req)
                    begin
                        pc <= pc_init;
                        halted <= 1'b0;
                        MEM_REQ <= 1'b1;
                        MEM_WE <= 1'b0;
                        MEM_ADDR <= pc_init;
                        state <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    if (MEM_ACK)
                    begin
                        MEM_REQ <= 1'b0;
                        instr <= MEM_RDATA;
                        state <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    if (!known)
                    begin
                        // unsupported words stop the core rather than guess
                        halted <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (is_load || is_store)
                    begin
                        MEM_REQ <= 1'b1;
                        MEM_WE <= is_store;
                        MEM_ADDR <= ls_word;
                        MEM_WDATA <= {pc, STORE_PAD, store_data};
                        state <= S_MEM;
                    end
                    else
                    begin
                        pc <= next_pc;
                        MEM_REQ <= 1'b1;
                        MEM_WE <= 1'b0;
                        MEM_ADDR <= next_pc;
                        state <= S_FETCH;
                    end
                end
                S_MEM:
                begin
                    if (MEM_ACK)
                    begin
                        pc <= pc_inc;
                        MEM_WE <= 1'b0;
                        MEM_ADDR <= pc_inc;
                        state <= S_FETCH;
                    end
                end
                default:
                begin
                    MEM_REQ <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // register file, counter and flags
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < NUM_GPR; i++)
                gpr[i] <= 16'h0000;
            stage_cnt <= 8'h00;
            zero_flag <= 1'b0;
            ovf_flag <= 1'b0;
        end
        else if (exec && (alu_reg || alu_imm))
        begin
            gpr[dest_index] <= alu_bus.result;
            zero_flag <= alu_bus.zero;
            if (arith)
                ovf_flag <= alu_bus.carry;
        end
        else if (exec && alu_cnt)
        begin
            stage_cnt <= next_cnt;
            zero_flag <= (next_cnt == 8'h00);
        end
        else if (state == S_MEM && MEM_ACK && !MEM_WE)
            gpr[dest_index] <= mem_low;
    end

    // ahb-lite slave: zero wait states, always OKAY
    wire ahb_go = HSEL && HTRANS[1] && HREADY;
    wire running = (state != S_IDLE);
    wire [PC_W-1:0] pc_init_fwd = (wr_pending && wr_addr == PC_INIT_OFS) ?
                                  HWDATA[PC_W-1:0] : pc_init;
    wire [31:0] status_word = {5'h00, pc, stage_cnt, 4'h0, ovf_flag, zero_flag,
                               halted, running};
    wire [31:0] rd_val =
        (HADDR[7:0] == PC_INIT_OFS) ? {21'h000000, pc_init_fwd} :
        (HADDR[7:0] == STATUS_OFS) ? status_word :
        (HADDR[7:4] == GPR_OFS[7:4] && HADDR[1:0] == 2'h0) ?
            {16'h0000, gpr[HADDR[3:2]]} :
        32'h0000_0000;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            pc_init <= 11'h000;
            start_req <= 1'b0;
        end
        else
        begin
            wr_pending <= ahb_go && HWRITE;
            wr_addr <= HADDR[7:0];
            if (ahb_go && !HWRITE)
                HRDATA <= rd_val;
            start_req <= wr_pending && (wr_addr == CTRL_OFS) && HWDATA[CTRL_START_BIT];
            pc_init <= pc_init_fwd;
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_store_issue;
        exec && is_store;
    endsequence
    sequence s_load_done;
        state == S_MEM && MEM_ACK && !MEM_WE;
    endsequence

    property p_store_word;
        s_store_issue |=> MEM_REQ && MEM_WE &&
            MEM_WDATA == {$past(pc), STORE_PAD, $past(store_data)};
    endproperty
    a_store_word: assert property (p_store_word) else $error("store word wrong");

    property p_store_addr;
        s_store_issue |=> MEM_ADDR == $past(ls_word) ##1 MEM_WE || MEM_ACK;
    endproperty
    a_store_addr: assert property (p_store_addr) else $error("store address wrong");

    property p_load_low;
        s_load_done |=> gpr[dest_index] == $past(mem_low) && state == S_FETCH;
    endproperty
    a_load_low: assert property (p_load_low) else $error("load data wrong");

    property p_flags_hold;
        exec && !is_alu |=> $stable(zero_flag) && $stable(ovf_flag);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag moved");

    property p_cnt_clear;
        exec && alu_cnt && alu_op_select == CNT_CLEAR_OP |=> stage_cnt == 8'h00 && zero_flag;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

    property p_abs_jump;
        exec && jump_abs && jump_type == JT_ALWAYS && !instr[21]
            |=> pc == $past(instr[2 +: PC_W]) && MEM_ADDR == pc && MEM_REQ;
    endproperty
    a_abs_jump: assert property (p_abs_jump) else $error("absolute jump wrong");

    property p_cnt_branch;
        exec && jump_cnt && !cnt_take |=> pc == $past(pc_inc);
    endproperty
    a_cnt_branch: assert property (p_cnt_branch) else $error("branch taken wrongly");

    // an add carries exactly when the wrapped sum falls below its first operand
    property p_overflow;
        exec && (alu_reg || alu_imm) && alu_op_select == ADD_OP |=>
            ovf_flag == (gpr[dest_index] < $past(alu_bus.a)) &&
            gpr[dest_index] == $past(alu_bus.result);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag wrong");
endmodule // coproc_core

// ===== tb/slow_mem_model.sv
// behavioural shared slow memory answering the core's word requests
`timescale 1ns/10ps
module slow_mem_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [10:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] lat,
    // answer side
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [31:0] words [0:2047];
    logic [3:0] wait_cnt;
    initial
    begin
        mem_rdata = 32'h0000_0000;
        mem_ack = 1'b0;
        wait_cnt = 4'h0;
    end
    // read data flips outside the ack cycle so a stale word never looks valid
    always @(posedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!rst_n)
            wait_cnt <= 4'h0;
        else if (mem_req && !mem_ack)
        begin
            if (wait_cnt >= lat)
            begin
                // one ack per request, whole words only
                mem_ack <= 1'b1;
                wait_cnt <= 4'h0;
                if (mem_we)
                    words[mem_addr] <= mem_wdata;
                else
                    mem_rdata <= words[mem_addr];
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // slow_mem_model

// ===== tb/tb_lowpower_coproc_alu_ldst_jump.sv
// self-checking bench for the coprocessor core and its memory port
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb_lowpower_coproc_alu_ldst_jump
    import coproc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] lat = 4'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic mem_req;
    logic mem_we;
    logic [PC_W-1:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic mem_ack;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] prog [0:63];
    logic [31:0] rd;
    logic [15:0] ex;
    always #2.5 core_clk = ~core_clk;
    coproc_core dut (.CORE_CLK(core_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MEM_REQ(mem_req),
        .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
        .MEM_ACK(mem_ack));
    slow_mem_model mem_model (.clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    function automatic logic [31:0] alu_r(input logic [3:0] s, input logic [1:0] d,
        input logic [1:0] a, input logic [1:0] b);
        return {ALU_OPCODE, ALU_REG_FORM, s, 15'h0000, b, a, d};
    endfunction
    function automatic logic [31:0] alu_i(input logic [3:0] s, input logic [1:0] d,
        input logic [1:0] a, input logic [15:0] imm);
        return {ALU_OPCODE, ALU_IMM_FORM, s, 1'b0, imm, a, d};
    endfunction
    function automatic logic [31:0] alu_c(input logic [3:0] s, input logic [7:0] imm);
        return {ALU_OPCODE, ALU_CNT_FORM, s, 9'h000, imm, 4'h0};
    endfunction
    function automatic logic [31:0] mem_op(input logic [3:0] op, input logic [2:0] sub,
        input logic [9:0] off, input logic [1:0] base, input logic [1:0] r);
        return {op, sub, 5'h00, off, 6'h00, base, r};
    endfunction
    function automatic logic [31:0] jabs(input logic [2:0] t, input logic sl,
        input logic [12:0] ad, input logic [1:0] r);
        return {JUMP_OPCODE, JUMP_ABS_FORM, t, sl, 6'h00, ad, r};
    endfunction
    function automatic logic [31:0] jr0(input logic [7:0] st, input logic c,
        input logic [15:0] th);
        return {JUMP_OPCODE, JUMP_REG_ZERO_FORM, st, c, th};
    endfunction
    function automatic logic [31:0] jcnt(input logic [7:0] st, input logic [1:0] c,
        input logic [7:0] th);
        return {JUMP_OPCODE, JUMP_CNT_FORM, st, c, 7'h00, th};
    endfunction
    function automatic logic [15:0] f_alu(input logic [3:0] s, input logic [15:0] a,
        input logic [15:0] b);
        case (s)
            ADD_OP: return a + b;
            SUB_OP: return a - b;
            AND_OP: return a & b;
            OR_OP: return a | b;
            SHIFT_LEFT_OP: return a << b;
            SHIFT_RIGHT_OP: return a >> b;
            default: return a;
        endcase
    endfunction
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            $display("[ERR] hready expected 1 seen %0h", hreadyout);
            summarize();
        end
    endtask
    // called just after a rising edge; address phase held until hready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask
    // fresh reset per program keeps the halted flag from leaking between runs
    task automatic run(input int n, input logic [3:0] l);
        int k;
        lat <= l;
        do_reset();
        for (int i = 0; i < 64; i++)
            mem_model.words[i] = (i < n) ? prog[i] : 32'hF000_0000;
        ahb(1'b1, PC_INIT_OFS, 32'h0, rd);
        ahb(1'b1, CTRL_OFS, 32'h1, rd);
        k = 0;
        do
        begin
            ahb(1'b0, STATUS_OFS, 32'h0, rd);
            k++;
        end
        while (rd[1] !== 1'b1 && k < 400);
        `CHK("halted", 1'b1, rd[1])
        if (rd[1] !== 1'b1)
            summarize();
    endtask
    task automatic t_reset();
        do_reset();
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        `CHK("status", 32'h0, rd)
        ahb(1'b1, GPR_OFS, 32'h0000_1234, rd);
        ahb(1'b0, GPR_OFS, 32'h0, rd);
        `CHK("gpr0", 32'h0, rd)
        ahb(1'b0, 8'h40, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic t_alu();
        for (int s = 0; s < 7; s++)
        begin
            prog[0] = alu_i(MOVE_OP, 2'd0, 2'd0, 16'h00F0);
            prog[1] = alu_i(MOVE_OP, 2'd1, 2'd0, 16'h0004);
            prog[2] = alu_r(4'(s), 2'd2, 2'd0, 2'd1);
            prog[3] = alu_i(4'(s), 2'd3, 2'd0, 16'h0014);
            run(4, 4'h0);
            ahb(1'b0, GPR_OFS + 8'h08, 32'h0, rd);
            `CHK("reg form", {16'h0, f_alu(4'(s), 16'h00F0, 16'h0004)}, rd)
            // immediate of twenty pushes both shifts past the word width
            ex = (s == 4) ? 16'h0014 : f_alu(4'(s), 16'h00F0, 16'h0014);
            ahb(1'b0, GPR_OFS + 8'h0C, 32'h0, rd);
            `CHK("imm form", {16'h0, ex}, rd)
            ahb(1'b0, STATUS_OFS, 32'h0, rd);
            `CHK("flags", {1'b0, ex == 16'h0}, rd[3:2])
        end
    endtask
    task automatic t_counter();
        prog[0] = alu_i(MOVE_OP, 2'd0, 2'd0, 16'h0001);
        prog[1] = alu_i(SUB_OP, 2'd1, 2'd0, 16'h0002);
        prog[2] = alu_c(CNT_INC_OP, 8'h07);
        prog[3] = alu_c(CNT_CLEAR_OP, 8'h00);
        prog[4] = alu_c(CNT_INC_OP, 8'h05);
        prog[5] = alu_c(CNT_INC_OP, 8'hFE);
        prog[6] = alu_c(COUNTER_DECREMENT_OP, 8'h01);
        prog[7] = jcnt(8'h02, 2'b10, 8'h02);
        prog[8] = alu_i(MOVE_OP, 2'd2, 2'd0, 16'h0001);
        prog[9] = jcnt(8'h02, 2'b00, 8'h02);
        prog[10] = alu_i(MOVE_OP, 2'd3, 2'd0, 16'h0007);
        prog[11] = jcnt(8'h02, 2'b01, 8'h01);
        prog[12] = alu_i(MOVE_OP, 2'd2, 2'd0, 16'h0002);
        prog[13] = alu_c(COUNTER_DECREMENT_OP, 8'h02);
        run(14, 4'h2);
        ahb(1'b0, GPR_OFS + 8'h04, 32'h0, rd);
        `CHK("borrow", 32'h0000_FFFF, rd)
        ahb(1'b0, GPR_OFS + 8'h08, 32'h0, rd);
        `CHK("taken", 32'h0, rd)
        ahb(1'b0, GPR_OFS + 8'h0C, 32'h0, rd);
        `CHK("not taken", 32'h7, rd)
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        `CHK("counter", 8'h00, rd[15:8])
        `CHK("cnt flags", 2'b11, rd[3:2])
    endtask
    task automatic t_jump();
        prog[0] = alu_i(MOVE_OP, 2'd0, 2'd0, 16'hFFFF);
        prog[1] = alu_i(MOVE_OP, 2'd1, 2'd0, 16'h0001);
        prog[2] = alu_r(ADD_OP, 2'd2, 2'd0, 2'd1);
        prog[3] = mem_op(STORE_WORD_OP, STORE_SUBFIELD, 10'h3FF, 2'd1, 2'd1);
        prog[4] = jabs(JT_OVF, 1'b0, 13'd7, 2'd0);
        prog[5] = alu_i(MOVE_OP, 2'd1, 2'd0, 16'h0033);
        prog[6] = 32'hF000_0000;
        prog[7] = alu_i(MOVE_OP, 2'd3, 2'd0, 16'd11);
        prog[8] = jabs(JT_ZERO, 1'b0, 13'd5, 2'd0);
        prog[9] = jabs(JT_ALWAYS, 1'b1, 13'd5, 2'd3);
        prog[10] = jabs(JT_ALWAYS, 1'b0, 13'd5, 2'd0);
        prog[11] = mem_op(LOAD_WORD_OP, 3'h0, 10'h3F5, 2'd3, 2'd0);
        prog[12] = jr0(8'h02, 1'b0, 16'h0001);
        prog[13] = jr0(8'h83, 1'b1, 16'h0001);
        prog[14] = alu_i(MOVE_OP, 2'd2, 2'd0, 16'h0055);
        run(15, 4'h3);
        // upper half carries pc 3 shifted by five; offset -1 from base 1 hits word 0
        `CHK("store word", 32'h0060_0001, mem_model.words[0])
        ahb(1'b0, GPR_OFS, 32'h0, rd);
        `CHK("load", 32'h1, rd)
        ahb(1'b0, GPR_OFS + 8'h04, 32'h0, rd);
        `CHK("abs imm jump", 32'h33, rd)
        ahb(1'b0, GPR_OFS + 8'h08, 32'h0, rd);
        `CHK("branch r0", 32'h0, rd)
        ahb(1'b0, GPR_OFS + 8'h0C, 32'h0, rd);
        `CHK("abs jump", 32'd11, rd)
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        `CHK("held flags", 2'b10, rd[3:2])
    endtask
    initial
    begin
        t_reset();
        t_alu();
        t_counter();
        t_jump();
        summarize();
    end
endmodule // tb_lowpower_coproc_alu_ldst_jump
